// ### design/edge_sync.sv
// Purpose: Two-flop synchroniser for a pin, with falling-edge detect.
// Assumes: Pin is asynchronous to sys_clk.
// Notes:   The first flop feeds only the second flop.
`timescale 1ns/1ps
module edge_sync
(
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic pin,
   output wire logic level,
   output wire logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_s;

   sync_s cur;
   sync_s next_cur;

   always_comb
   begin
      next_cur    = cur;
      next_cur.s1 = pin;
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign level = cur.s2;
   assign fall  = cur.s3 & ~cur.s2;
endmodule // edge_sync

// ### design/tap_fsm.sv
// Purpose: Sixteen-state test access port controller, stepped by enable.
// Assumes: step is a one-cycle pulse per test clock; tms valid with it.
// Notes:   restart forces the reset state regardless of step.
`timescale 1ns/1ps
module tap_fsm
   import two_wire_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       restart,
   input  wire logic       step,
   input  wire logic       tms,
   output tap_state_e      state
);
   typedef struct packed {
      tap_state_e st;
   } tap_s;

   tap_s cur;
   tap_s next_cur;

   always_comb
   begin
      next_cur = cur;
      if (restart)
         next_cur.st = TLR;
      else if (step)
      begin
         // Mode patterns on tms walk the machine; tdi is ignored here.
         unique case (cur.st)
            TLR:   next_cur.st = tms ? TLR   : RTI;
            RTI:   next_cur.st = tms ? SELDR : RTI;
            SELDR: next_cur.st = tms ? SELIR : CAPDR;
            CAPDR: next_cur.st = tms ? EX1DR : SHDR;
            SHDR:  next_cur.st = tms ? EX1DR : SHDR;
            EX1DR: next_cur.st = tms ? UPDR  : PADR;
            PADR:  next_cur.st = tms ? EX2DR : PADR;
            EX2DR: next_cur.st = tms ? UPDR  : SHDR;
            UPDR:  next_cur.st = tms ? SELDR : RTI;
            SELIR: next_cur.st = tms ? TLR   : CAPIR;
            CAPIR: next_cur.st = tms ? EX1IR : SHIR;
            SHIR:  next_cur.st = tms ? EX1IR : SHIR;
            EX1IR: next_cur.st = tms ? UPIR  : PAIR;
            PAIR:  next_cur.st = tms ? EX2IR : PAIR;
            EX2IR: next_cur.st = tms ? UPIR  : SHIR;
            UPIR:  next_cur.st = tms ? SELDR : RTI;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         cur <= '{st: TLR};
      else
         cur <= next_cur;
   end

   assign state = cur.st;
endmodule // tap_fsm

// ### design/two_wire_pkg.sv
// Purpose: Shared constants and types for the two-wire program port.
// Assumes: 250 MHz system clock, 5-bit instruction register.
// Notes:   Instruction codes are local choices with plain values.
package two_wire_pkg;
   localparam int          SYS_CLK_HZ    = 250_000_000;
   localparam int          CPU_CLK_HZ    = 8_000_000;
   localparam int          CPU_ACC_W     = 28;
   localparam logic [1:0]  PH4_TDI       = 2'h0;
   localparam logic [1:0]  PH4_TMS       = 2'h1;
   localparam logic [1:0]  PH4_TURN      = 2'h2;
   localparam logic [1:0]  PH4_OUT       = 2'h3;
   localparam logic [1:0]  PH2_TMS       = 2'h0;
   localparam logic [1:0]  PH2_TDI       = 2'h1;
   localparam int          IR_W          = 5;
   localparam int          DR_W          = 32;
   localparam logic [4:0]  IR_RESET      = 5'h1f;
   localparam logic [4:0]  IR_CAPTURE    = 5'h01;
   localparam logic [4:0]  IR_SW_VENDOR  = 5'h04;
   localparam logic [4:0]  IR_SW_DEBUG   = 5'h05;
   localparam logic [4:0]  IR_COMMAND    = 5'h07;
   localparam logic [4:0]  IR_INSTR_DATA = 5'h09;
   localparam logic [31:0] DSEG_LO       = 32'hff200000;
   localparam logic [31:0] DSEG_HI       = 32'hff2fffff;
   localparam logic [31:0] BOOT_BASE     = 32'h1fc00000;
   localparam logic [31:0] PROG_BASE     = 32'h1d000000;
   localparam logic [31:0] BOOT_BYTES    = 32'h00000c00;
   localparam logic [31:0] PROG_BYTES    = 32'h00004000;
   localparam int          PAGE_WORDS    = 256;
   localparam int          ROWS_PER_PAGE = 8;

   typedef enum logic [3:0] {
      TLR   = 4'h0, RTI   = 4'h1, SELDR = 4'h2, CAPDR = 4'h3,
      SHDR  = 4'h4, EX1DR = 4'h5, PADR  = 4'h6, EX2DR = 4'h7,
      UPDR  = 4'h8, SELIR = 4'h9, CAPIR = 4'ha, SHIR  = 4'hb,
      EX1IR = 4'hc, PAIR  = 4'hd, EX2IR = 4'he, UPIR  = 4'hf
   } tap_state_e;
endpackage

// ### design/two_wire_program_port.sv
// Purpose: Two-wire serial program port, demultiplexed to a four-wire
//          test port feeding a shared vendor/debug TAP.
// Assumes: Link clock and data arrive on pins, asynchronous to sys_clk.
// Notes:   Each falling link-clock edge found by sampling is one phase.
`timescale 1ns/1ps
module two_wire_program_port
   import two_wire_pkg::*;
#(
   parameter int          PAGE_W  = PAGE_WORDS,
   parameter logic [31:0] BOOT_SZ = BOOT_BYTES,
   parameter logic [31:0] PROG_SZ = PROG_BYTES
)
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        progClk,
   input  wire logic        progDataIn,
   output wire logic        progDataOut,
   output wire logic        progDataOe,
   input  wire logic        serialModeOn,
   input  wire logic        twoPhaseReq,
   input  wire logic        dataOutEnable,
   input  wire logic        debugMode,
   input  wire logic [31:0] statusWord,
   input  wire logic [31:0] cpuAddr,
   output wire logic [31:0] cmdWord,
   output wire logic        cmdValid,
   output wire logic [31:0] instrWord,
   output wire logic        instrValid,
   output wire logic        debugTapSel,
   output wire logic        segGrant,
   output wire logic        segFault,
   output wire logic        bootHit,
   output wire logic        programHit,
   output wire logic [2:0]  rowIndex
);
   // Row size is page size over eight, so a row is 32, 128 or 512 words.
   localparam int ROW_W   = PAGE_W / ROWS_PER_PAGE;
   localparam int ROW_LSB = 2 + $clog2(ROW_W);

   typedef struct packed {
      logic                 modeOn;
      logic [1:0]           phase;
      logic                 tdi;
      logic                 tms;
      logic                 pend;
      logic                 pTdi;
      logic                 pTms;
      logic [IR_W-1:0]      irShift;
      logic [IR_W-1:0]      ir;
      logic [DR_W-1:0]      drShift;
      logic                 bypassBit;
      logic                 debugSel;
      logic [DR_W-1:0]      cmdWord;
      logic                 cmdValid;
      logic [DR_W-1:0]      instrWord;
      logic                 instrPend;
      logic                 instrValid;
      logic [CPU_ACC_W-1:0] acc;
      logic                 cpuTick;
      logic                 outOe;
      logic                 outBit;
      logic                 segGrant;
      logic                 segFault;
      logic                 bootHit;
      logic                 programHit;
      logic [2:0]           rowIndex;
   } port_s;

   port_s      cur;
   port_s      next_cur;
   tap_state_e tapState;
   logic       clkFall;
   logic       dataLevel;
   logic       entry;
   logic       fall;
   logic       twoPh;
   logic       step;
   logic       stepTms;
   logic       stepTdi;
   logic       useBypass;
   logic       shifting;
   logic       tdoVal;

   // The link clock is only sampled, never used as a clock, so both pins
   // see identical latency and the data phase lines up with its edge.
   edge_sync u_clk_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .pin     (progClk),
      .level   (),
      .fall    (clkFall)
   );

   edge_sync u_data_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .pin     (progDataIn),
      .level   (dataLevel),
      .fall    ()
   );

   assign entry = serialModeOn & ~cur.modeOn;
   assign fall  = clkFall & cur.modeOn & ~entry;
   assign twoPh = twoPhaseReq & ~dataOutEnable;

   // Four-phase steps the TAP once the data-out phase has gone by; the
   // two-phase packet waits for the first clock of the next one.
   assign step    = fall & (twoPh ? (cur.phase == PH2_TMS) & cur.pend
                                  : (cur.phase == PH4_OUT));
   assign stepTms = twoPh ? cur.pTms : cur.tms;
   assign stepTdi = twoPh ? cur.pTdi : cur.tdi;

   assign useBypass = !((!cur.debugSel && cur.ir == IR_COMMAND) ||
                        ( cur.debugSel && cur.ir == IR_INSTR_DATA));
   assign shifting  = (tapState == SHDR) || (tapState == SHIR);
   assign tdoVal    = (tapState == SHIR) ? cur.irShift[0] :
                      useBypass ? cur.bypassBit : cur.drShift[0];

   tap_fsm u_tap (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .restart (entry),
      .step    (step),
      .tms     (stepTms),
      .state   (tapState)
   );

   always_comb
   begin
      next_cur            = cur;
      next_cur.modeOn     = serialModeOn;
      next_cur.cmdValid   = 1'b0;
      next_cur.instrValid = 1'b0;
      next_cur.cpuTick    = 1'b0;

      if (entry)
      begin
         next_cur.phase = 2'h0;
         next_cur.pend  = 1'b0;
         next_cur.outOe = 1'b0;
      end
      else if (fall)
      begin
         if (twoPh)
         begin
            next_cur.outOe = 1'b0;
            next_cur.phase = {1'b0, ~cur.phase[0]};
            if (cur.phase == PH2_TMS)
               next_cur.tms = dataLevel;
            else
            begin
               next_cur.pTms = cur.tms;
               next_cur.pTdi = dataLevel;
               next_cur.pend = 1'b1;
            end
         end
         else
         begin
            next_cur.pend  = 1'b0;
            next_cur.phase = cur.phase + 2'h1;
            unique case (cur.phase)
               PH4_TDI:  next_cur.tdi = dataLevel;
               PH4_TMS:  next_cur.tms = dataLevel;
               PH4_TURN:
               begin
                  next_cur.outOe  = shifting;
                  next_cur.outBit = tdoVal;
               end
               PH4_OUT:  next_cur.outOe = 1'b0;
            endcase
         end
      end

      if (step)
      begin
         unique case (tapState)
            TLR:
            begin
               next_cur.ir       = IR_RESET;
               next_cur.debugSel = 1'b0;
            end
            CAPIR: next_cur.irShift = IR_CAPTURE;
            SHIR:  next_cur.irShift = {stepTdi, cur.irShift[IR_W-1:1]};
            UPIR:
            begin
               // The instruction is held until the next update, so
               // repeated command shifts need no reload.
               next_cur.ir = cur.irShift;
               if (cur.irShift == IR_SW_DEBUG)
                  next_cur.debugSel = 1'b1;
               else if (cur.irShift == IR_SW_VENDOR)
                  next_cur.debugSel = 1'b0;
            end
            CAPDR:
            begin
               next_cur.drShift   = cur.debugSel ? '0 : statusWord;
               next_cur.bypassBit = 1'b0;
            end
            SHDR:
            begin
               if (useBypass)
                  next_cur.bypassBit = stepTdi;
               else
                  next_cur.drShift = {stepTdi, cur.drShift[DR_W-1:1]};
            end
            UPDR:
            begin
               if (!cur.debugSel && cur.ir == IR_COMMAND)
               begin
                  next_cur.cmdWord  = cur.drShift;
                  next_cur.cmdValid = 1'b1;
               end
               else if (cur.debugSel && cur.ir == IR_INSTR_DATA)
                  next_cur.instrWord = cur.drShift;
            end
            default:
            begin
            end
         endcase
      end

      // Fractional divider gives an exact 8 MHz average tick from 250 MHz.
      if ({4'h0, cur.acc} + CPU_CLK_HZ >= SYS_CLK_HZ)
      begin
         next_cur.acc     = CPU_ACC_W'({4'h0, cur.acc} + CPU_CLK_HZ - SYS_CLK_HZ);
         next_cur.cpuTick = 1'b1;
      end
      else
         next_cur.acc = CPU_ACC_W'({4'h0, cur.acc} + CPU_CLK_HZ);

      if (cur.instrPend && cur.cpuTick)
      begin
         next_cur.instrPend  = 1'b0;
         next_cur.instrValid = 1'b1;
      end
      // A new word in the same cycle as a hand-over stays pending.
      if (step && tapState == UPDR && cur.debugSel && cur.ir == IR_INSTR_DATA)
         next_cur.instrPend = 1'b1;

      next_cur.segGrant   = (cpuAddr >= DSEG_LO) && (cpuAddr <= DSEG_HI) && debugMode;
      next_cur.segFault   = (cpuAddr >= DSEG_LO) && (cpuAddr <= DSEG_HI) && !debugMode;
      next_cur.bootHit    = (cpuAddr - BOOT_BASE) < BOOT_SZ;
      next_cur.programHit = (cpuAddr - PROG_BASE) < PROG_SZ;
      next_cur.rowIndex   = cpuAddr[ROW_LSB +: 3];

      if (!serialModeOn)
         next_cur.outOe = 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign progDataOut = cur.outBit;
   assign progDataOe  = cur.outOe;
   assign cmdWord     = cur.cmdWord;
   assign cmdValid    = cur.cmdValid;
   assign instrWord   = cur.instrWord;
   assign instrValid  = cur.instrValid;
   assign debugTapSel = cur.debugSel;
   assign segGrant    = cur.segGrant;
   assign segFault    = cur.segFault;
   assign bootHit     = cur.bootHit;
   assign programHit  = cur.programHit;
   assign rowIndex    = cur.rowIndex;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_drive_shift_only: assert property (
      progDataOe |-> shifting) else $error("data out driven outside shift");
   a_two_phase_quiet: assert property (
      twoPh |=> !progDataOe) else $error("data out driven in two-phase");
   a_drive_on_turn: assert property (
      $rose(progDataOe) |-> $past(fall) && $past(cur.phase) == PH4_TURN)
      else $error("data out started off the turnaround edge");
   a_entry_align: assert property (
      $rose(serialModeOn) |=> cur.phase == 2'h0 && !cur.pend)
      else $error("phase not realigned on entry");
   a_seg_guard: assert property (
      segGrant |-> $past(debugMode) && $past(cpuAddr) >= DSEG_LO)
      else $error("debug segment granted outside debug mode");
   a_cmd_selected: assert property (
      cmdValid |-> cur.ir == IR_COMMAND && !cur.debugSel)
      else $error("command issued without command instruction");
   a_instr_rate: assert property (
      instrValid |-> $past(cur.cpuTick) && !cur.cpuTick)
      else $error("instruction handed over off the cpu tick");
   a_lsb_first: assert property (
      step && tapState == SHDR && !useBypass |=> cur.drShift[31] == $past(stepTdi))
      else $error("data register not shifted lsb first");
   a_defer_packet: assert property (
      step && twoPh |-> cur.phase == PH2_TMS && cur.pend)
      else $error("two-phase packet acted on early");
   a_tdi_phase: assert property (
      fall && !twoPh && cur.phase == PH4_TDI |=> cur.tdi == $past(dataLevel))
      else $error("data-in phase not captured");

   c_entry:   cover property ($rose(serialModeOn));
   c_readout: cover property ($rose(progDataOe));
   c_command: cover property (cmdValid);
   c_instr:   cover property (instrValid);
endmodule // two_wire_program_port

// ### verif/program_probe_model.sv
// Purpose: Behavioural programmer probe that drives the link clock and data pin.
// Assumes: Link clock period 80 ns; the clock stands high between frames.
// Notes:   A pin released by both parties shows the inverse of its last value, so a
//          device that samples a floating pin cannot pass by luck.
`timescale 1ns/1ps
module program_probe_model
(
   output logic      progClk,
   output wire logic pin,
   input  wire logic progDataOut,
   input  wire logic progDataOe
);
   logic probeOe;
   logic probeData;
   logic holdVal;

   assign pin = progDataOe ? progDataOut : (probeOe ? probeData : holdVal);

   initial
   begin
      progClk = 1'b1;
      probeOe = 1'b0;
      probeData = 1'b0;
      holdVal = 1'b1;
   end

   always @(negedge progDataOe)
   begin
      holdVal = ~progDataOut;
   end

   // Data changes just after the rising edge and is held through the falling edge.
   task phase(input bit drv, input bit val, output logic smp);
      if (!drv && probeOe)
         holdVal = ~probeData;
      probeOe = drv;
      probeData = val;
      #39;
      smp = pin;
      #1 progClk = 1'b0;
      #40 progClk = 1'b1;
   endtask

   task slot(input bit twoPh, input bit tms, input bit tdi, output logic tdo);
      logic unused;
      tdo = 1'b0;
      if (twoPh)
      begin
         phase(1'b1, tms, unused);
         phase(1'b1, tdi, unused);
      end
      else
      begin
         phase(1'b1, tdi, unused);
         phase(1'b1, tms, unused);
         phase(1'b0, 1'b0, unused);
         phase(1'b0, 1'b0, tdo);
      end
   endtask
endmodule // program_probe_model

// ### verif/two_wire_serial_program_port_tb_top.sv
// Purpose: Self-checking bench for the two-wire program port.
// Assumes: Default design parameters; link clock 80 ns, system clock 4 ns.
// Notes:   Expected words are queued by the bench model and popped at each pulse.
`timescale 1ns/1ps
module two_wire_serial_program_port_tb_top
   import two_wire_pkg::*;
();
   localparam int ROW_LSB = 2 + $clog2(PAGE_WORDS / ROWS_PER_PAGE);
   logic        sys_clk = 1'b0;
   logic        resetn, serialModeOn, twoPhaseReq, dataOutEnable, debugMode;
   logic        progClk, progDataOut, progDataOe, cmdValid, instrValid, debugTapSel;
   logic        segGrant, segFault, bootHit, programHit, oePrev, twoPh, tapSel, b;
   wire         pin;
   logic [2:0]  rowIndex;
   logic [4:0]  irModel;
   logic [31:0] statusWord, cpuAddr, cmdWord, instrWord, rng, d, a, e;
   logic [31:0] expCmd[$];
   logic [31:0] expInstr[$];
   int          failCount = 0;
   int          checked = 0;
   int          cycles = 0;
   int          oeRise = 0;
   logic [31:0] addrTab[11] = '{DSEG_LO, DSEG_HI, DSEG_HI + 32'h1, DSEG_LO - 32'h1,
      BOOT_BASE, BOOT_BASE + BOOT_BYTES - 32'h1, BOOT_BASE + BOOT_BYTES, PROG_BASE,
      PROG_BASE + PROG_BYTES - 32'h1, PROG_BASE + PROG_BYTES, PROG_BASE + 32'h380};

   always #2 sys_clk = ~sys_clk;

   program_probe_model probe (.progClk, .pin, .progDataOut, .progDataOe);

   two_wire_program_port dut
   (
      .sys_clk, .resetn, .progClk, .progDataIn(pin), .progDataOut, .progDataOe,
      .serialModeOn, .twoPhaseReq, .dataOutEnable, .debugMode, .statusWord, .cpuAddr,
      .cmdWord, .cmdValid, .instrWord, .instrValid, .debugTapSel, .segGrant, .segFault,
      .bootHit, .programHit, .rowIndex
   );

   function automatic logic [31:0] xorshift();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         failCount++;
      end
   endtask

   task complete_run();
      $display("Counts: %0d checks, %0d mismatches", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Pulses are compared against the model queues at the cycle they stand.
   always @(negedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failCount++;
         complete_run();
      end
      if (resetn && progDataOe && !oePrev)
         oeRise++;
      oePrev = progDataOe;
      if (cmdValid === 1'b1)
         check("cmdWord", (expCmd.size() > 0) ? expCmd.pop_front() : ~cmdWord, cmdWord);
      if (instrValid === 1'b1)
         check("instrWord", (expInstr.size() > 0) ? expInstr.pop_front() : ~instrWord,
               instrWord);
   end

   task enter_serial();
      @(negedge sys_clk) serialModeOn = 1'b0;
      @(negedge sys_clk) serialModeOn = 1'b1;
      @(negedge sys_clk);
      irModel = IR_RESET;
      tapSel = 1'b0;
   endtask

   task set_mode();
      for (int i = 0; i < 6; i++)
         probe.slot(twoPh, bit'(6'h1f >> i), 1'b0, b);
   endtask

   // Header, body LSB first with the last bit raising mode-select, then footer 1,0.
   task automatic shift(input bit isIr, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
      dout = '0;
      oeRise = 0;
      for (int i = 0; i < (isIr ? 4 : 3); i++)
         probe.slot(twoPh, isIr ? (i < 2) : (i == 0), 1'b0, b);
      for (int i = 0; i < n; i++)
      begin
         probe.slot(twoPh, i == n - 1, din[i], b);
         dout[i] = b;
      end
      // Expectations are queued before the footer, because in four-phase mode the update pulse
      // comes within the footer's last clock, before this task returns; two-phase defers it to the next slot.
      if (isIr)
      begin
         irModel = din[4:0];
         if (din[4:0] == IR_SW_VENDOR || din[4:0] == IR_SW_DEBUG)
            tapSel = (din[4:0] == IR_SW_DEBUG);
      end
      else if (!tapSel && irModel == IR_COMMAND)
         expCmd.push_back(din);
      else if (tapSel && irModel == IR_INSTR_DATA)
         expInstr.push_back(din);
      probe.slot(twoPh, 1'b1, 1'b0, b);
      probe.slot(twoPh, 1'b0, 1'b0, b);
      repeat (4) @(negedge sys_clk);
      check("oe rises", twoPh ? 0 : n, oeRise);
   endtask

   initial
   begin
      {resetn, serialModeOn, debugMode, twoPh, oePrev} = '0;
      {twoPhaseReq, dataOutEnable} = 2'b11;
      {statusWord, cpuAddr} = '0;
      rng = 32'd46;
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk) resetn = 1'b1;
      @(negedge sys_clk);
      check("idle outputs", 32'h0, 32'({cmdValid, instrValid, progDataOe, debugTapSel,
            segGrant, segFault, bootHit, programHit, rowIndex}));
      // Two-phase is requested but the data-out enable bit is set: stays four-phase.
      statusWord = xorshift();
      enter_serial();
      set_mode();
      shift(1'b1, 5, 32'(IR_SW_VENDOR), d);
      check("ir capture", 32'(IR_CAPTURE), {27'h0, d[4:0]});
      shift(1'b1, 5, 32'(IR_COMMAND), d);
      for (int k = 0; k < 2; k++)
      begin
         shift(1'b0, 32, xorshift(), d);
         check("status read", statusWord, d);
      end
      check("tap select", 32'(tapSel), 32'(debugTapSel));
      $display("Test four-phase command done");
      debugMode = 1'b1;
      shift(1'b1, 5, 32'(IR_SW_DEBUG), d);
      check("tap select", 32'(tapSel), 32'(debugTapSel));
      shift(1'b1, 5, 32'(IR_INSTR_DATA), d);
      shift(1'b0, 32, xorshift(), d);
      check("debug capture", 32'h0, d);
      repeat (40) @(negedge sys_clk);
      check("instr left", 32'h0, expInstr.size());
      shift(1'b1, 5, 32'(IR_SW_VENDOR), d);
      check("tap select", 32'(tapSel), 32'(debugTapSel));
      // The switch instruction selects no register, so data goes through bypass.
      a = xorshift();
      shift(1'b0, 8, a, d);
      check("bypass", {24'h0, a[6:0], 1'b0}, d);
      $display("Test debug instruction done");
      for (int i = 0; i < 12; i++)
      begin
         a = (i == 11) ? xorshift() : addrTab[i];
         for (int dm = 0; dm < 2; dm++)
         begin
            cpuAddr = a;
            debugMode = dm[0];
            @(negedge sys_clk);
            e = (a >= DSEG_LO) && (a <= DSEG_HI);
            e = {e[0] && dm[0], e[0] && !dm[0], (a - BOOT_BASE) < BOOT_BYTES,
                 (a - PROG_BASE) < PROG_BYTES, a[ROW_LSB +: 3]};
            check("decode", e, 32'({segGrant, segFault, bootHit, programHit, rowIndex}));
         end
      end
      $display("Test address decode done");
      // Leave the phase counter mid-slot, then re-enter in two-phase mode.
      probe.phase(1'b1, 1'b0, b);
      probe.phase(1'b1, 1'b0, b);
      @(negedge sys_clk) dataOutEnable = 1'b0;
      twoPh = 1'b1;
      enter_serial();
      set_mode();
      shift(1'b1, 5, 32'(IR_SW_VENDOR), d);
      shift(1'b1, 5, 32'(IR_COMMAND), d);
      shift(1'b0, 32, xorshift(), d);
      repeat (20) @(negedge sys_clk);
      check("cmd deferred", 32'h1, expCmd.size());
      probe.slot(1'b1, 1'b0, 1'b0, b);
      repeat (20) @(negedge sys_clk);
      check("cmd released", 32'h0, expCmd.size());
      check("oe in two-phase", 32'h0, oeRise);
      $display("Test two-phase write done");
      complete_run();
   end
endmodule // two_wire_serial_program_port_tb_top
